// ### burst_ctr.sv
// Two-bit burst address counter with linear and interleaved order
module burst_ctr (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic load,
    input wire logic step,
    input wire logic [1:0] start_lo,
    input wire logic linear_order_n,
    // Address low bits
    output logic [1:0] cur_lo,
    output logic [1:0] next_lo
);
    logic [1:0] base;
    logic [1:0] cnt;
    logic [1:0] next_cnt;

    function automatic logic [1:0] order(input logic [1:0] b, input logic [1:0] c, input logic lin_n);
        order = lin_n ? (b ^ c) : 2'(b + c);
    endfunction

    // ==========================================================
    // Counter state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base <= 2'h0;
            cnt <= 2'h0;
        end else if (load) begin
            base <= start_lo;
            cnt <= 2'h0;
        end else if (step) begin
            cnt <= next_cnt;
        end
    end

    // Two-bit count wraps back to the start on the fifth clock
    assign next_cnt = 2'(cnt + 2'h1);
    assign cur_lo = order(base, cnt, linear_order_n);
    assign next_lo = order(base, next_cnt, linear_order_n);
endmodule

// ### sbs_cycle_ctrl.sv
// Burst SRAM synchronous cycle decode, data path and APB control slave
//
// Overview of operation
// - Deselect on disabled strobe; pins high impedance
// - Enabled processor strobe starts read burst
// - Controller strobe starts burst, write qualifier decides
// - Both strobes high, step low: next address
// - Step high: repeat current address, no advance
// - Primary enable high: processor strobe ignored
// - Global write all lanes; byte write enabled lanes
// - Any lane mix; no lane stores nothing
// - Reads drive all present lanes
// - Writes keep every lane high impedance
// - Lanes c and d only in wide configurations
// - Output enable high disables drivers asynchronously
// - Drive only during read outcomes
// - Dummy reads advance counter like normal reads
// - Every listed control combination is supported
// - Linear or interleaved order, wraps on fifth clock
// - Flow-through bypass select; sleep enters standby
module sbs_cycle_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Enables and strobes
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_high,
    input wire logic chip_sel_third_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_step_n,
    // Write controls
    input wire logic global_write_n,
    input wire logic byte_write_n,
    input wire logic lane_a_wr_n,
    input wire logic lane_b_wr_n,
    input wire logic lane_c_wr_n,
    input wire logic lane_d_wr_n,
    // Mode pins
    input wire logic out_en_n,
    input wire logic sleep_req,
    input wire logic flow_thru_sel_n,
    input wire logic linear_order_n,
    // Address and data
    input wire logic [17:0] sram_addr,
    input wire logic [35:0] dq_in,
    output logic [35:0] dq_out,
    output logic [3:0] dq_oe_n
);
    localparam int W = sbs_pkg::DATA_W;
    localparam int LW = sbs_pkg::LANE_W;

    logic [35:0] mem [0:sbs_pkg::DEPTH-1];
    sbs_pkg::op_t op;
    sbs_pkg::op_t last_op;
    logic chip_en;
    logic wr_q;
    logic [3:0] lane_wr;
    logic [3:0] lane_present;
    logic [35:0] bit_mask;
    logic is_rd;
    logic is_wr;
    logic is_begin;
    logic is_cont;
    logic [1:0] cur_lo;
    logic [1:0] next_lo;
    logic [1:0] cyc_lo;
    logic [15:0] addr_hi;
    logic [15:0] cyc_hi;
    logic [17:0] cyc_addr;
    logic [35:0] rd_word;
    logic [35:0] stage_data;
    logic stage_rd;
    logic drive_q;
    logic [1:0] width_cfg;
    logic [15:0] wr_count;
    logic apb_access;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // ==========================================================
    // Cycle decode
    assign chip_en = !chip_sel_primary_n && chip_sel_high && !chip_sel_third_n;
    assign wr_q = !global_write_n || !byte_write_n;

    always_comb begin
        op = sbs_pkg::op_deselect;
        if (sleep_req) begin
            op = sbs_pkg::op_deselect;
        end else if (!chip_sel_primary_n && !chip_en && (!proc_addr_strobe_n || !ctrl_addr_strobe_n)) begin
            op = sbs_pkg::op_deselect;
        end else if (chip_sel_primary_n && !ctrl_addr_strobe_n) begin
            op = sbs_pkg::op_deselect;
        end else if (chip_en && !proc_addr_strobe_n) begin
            op = sbs_pkg::op_begin_rd;
        end else if (chip_en && !ctrl_addr_strobe_n) begin
            op = wr_q ? sbs_pkg::op_begin_wr : sbs_pkg::op_begin_rd;
        end else if (!burst_step_n) begin
            // Primary enable high reaches here whatever the processor strobe
            op = wr_q ? sbs_pkg::op_cont_wr : sbs_pkg::op_cont_rd;
        end else begin
            op = wr_q ? sbs_pkg::op_susp_wr : sbs_pkg::op_susp_rd;
        end
    end

    assign is_begin = (op == sbs_pkg::op_begin_rd) || (op == sbs_pkg::op_begin_wr);
    assign is_cont = (op == sbs_pkg::op_cont_rd) || (op == sbs_pkg::op_cont_wr);
    assign is_wr = (op == sbs_pkg::op_begin_wr) || (op == sbs_pkg::op_cont_wr) || (op == sbs_pkg::op_susp_wr);
    assign is_rd = (op != sbs_pkg::op_deselect) && !is_wr;

    // ==========================================================
    // Burst address
    // Output enable plays no part here, so dummy reads step alike
    burst_ctr u_burst (
        .pclk(pclk),
        .presetn(presetn),
        .load(is_begin),
        .step(is_cont),
        .start_lo(sram_addr[1:0]),
        .linear_order_n(linear_order_n),
        .cur_lo(cur_lo),
        .next_lo(next_lo)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_hi <= 16'h0000;
        end else if (is_begin) begin
            addr_hi <= sram_addr[17:2];
        end
    end

    always_comb begin
        cyc_hi = addr_hi;
        cyc_lo = cur_lo;
        if (is_begin) begin
            cyc_hi = sram_addr[17:2];
            cyc_lo = sram_addr[1:0];
        end else if (is_cont) begin
            cyc_lo = next_lo;
        end
    end
    assign cyc_addr = {cyc_hi, cyc_lo};

    // ==========================================================
    // Lane qualification
    always_comb begin
        lane_present = 4'hf;
        bit_mask = '1;
        if (width_cfg == sbs_pkg::WIDTH_X18) begin
            lane_present = 4'h3;
            bit_mask = {18'h00000, 18'h3ffff};
        end else if (width_cfg == sbs_pkg::WIDTH_X32) begin
            bit_mask = {4{9'h0ff}};
        end
    end

    always_comb begin
        lane_wr = 4'h0;
        if (is_wr) begin
            if (!global_write_n) begin
                lane_wr = 4'hf;
            end else begin
                // Each lane is independent; none enabled stores nothing
                lane_wr = ~{lane_d_wr_n, lane_c_wr_n, lane_b_wr_n, lane_a_wr_n};
            end
            lane_wr = lane_wr & lane_present;
        end
    end

    // ==========================================================
    // Storage array, no reset so contents survive sleep
    always_ff @(posedge pclk) begin
        for (int i = 0; i < sbs_pkg::LANES; i++) begin
            if (lane_wr[i]) begin
                mem[cyc_addr][i*LW +: LW] <= dq_in[i*LW +: LW] & bit_mask[i*LW +: LW];
            end
        end
    end

    assign rd_word = mem[cyc_addr] & bit_mask;

    // ==========================================================
    // Output path: flow-through bypasses the output stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_data <= '0;
            stage_rd <= 1'b0;
        end else begin
            stage_data <= rd_word;
            stage_rd <= is_rd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_out <= '0;
            drive_q <= 1'b0;
        end else if (!flow_thru_sel_n) begin
            dq_out <= rd_word;
            drive_q <= is_rd;
        end else begin
            dq_out <= stage_data;
            // A write cycle always turns the drivers off at once
            drive_q <= stage_rd && !is_wr;
        end
    end

    // Not registered: output enable must act without the clock
    assign dq_oe_n = ~({4{drive_q && !out_en_n}} & lane_present);

    // ==========================================================
    // APB slave, one wait state per access
    assign apb_access = psel && penable && !pready;

    always_comb begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            sbs_pkg::CTRL_OFF: begin
                next_prdata[sbs_pkg::CTRL_WIDTH_LSB +: 2] = width_cfg;
            end
            sbs_pkg::STATUS_OFF: begin
                next_prdata[sbs_pkg::STAT_OP_LSB +: 3] = last_op;
                next_prdata[sbs_pkg::STAT_LO_LSB +: 2] = cur_lo;
                next_prdata[sbs_pkg::STAT_SLEEP_BIT] = sleep_req;
                next_prdata[sbs_pkg::STAT_FLOW_BIT] = !flow_thru_sel_n;
                next_prdata[sbs_pkg::STAT_DRIVE_BIT] = drive_q;
            end
            sbs_pkg::WRCNT_OFF: begin
                next_prdata[sbs_pkg::WRCNT_W-1:0] = wr_count;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
        if (pwrite) begin
            next_prdata = 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access && next_pslverr;
            prdata <= apb_access ? next_prdata : 32'h00000000;
        end
    end

    // Write takes effect at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_cfg <= sbs_pkg::CTRL_RESET;
        end else if (psel && penable && pready && pwrite && paddr == sbs_pkg::CTRL_OFF) begin
            if (pwdata[1:0] <= sbs_pkg::WIDTH_X36) begin
                width_cfg <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_op <= sbs_pkg::op_deselect;
            wr_count <= sbs_pkg::WRCNT_RESET;
        end else begin
            last_op <= op;
            if (lane_wr != 4'h0) begin
                wr_count <= 16'(wr_count + 16'h0001);
            end
        end
    end

    // ==========================================================
    // Assertions
    property p_desel_hiz;
        @(posedge pclk) disable iff (!presetn)
        (op == sbs_pkg::op_deselect && !flow_thru_sel_n) |=> (dq_oe_n == 4'hf);
    endproperty
    a_desel_hiz: assert property (p_desel_hiz) else $error("deselect left drivers on");

    property p_proc_begin;
        @(posedge pclk) disable iff (!presetn)
        (chip_en && !proc_addr_strobe_n && !sleep_req) |-> (op == sbs_pkg::op_begin_rd);
    endproperty
    a_proc_begin: assert property (p_proc_begin) else $error("processor strobe did not begin read");

    property p_ctrl_begin;
        @(posedge pclk) disable iff (!presetn)
        (chip_en && proc_addr_strobe_n && !ctrl_addr_strobe_n && !sleep_req)
        |-> (op == (wr_q ? sbs_pkg::op_begin_wr : sbs_pkg::op_begin_rd));
    endproperty
    a_ctrl_begin: assert property (p_ctrl_begin) else $error("controller strobe begin wrong");

    property p_begin_load;
        logic [1:0] a;
        @(posedge pclk) disable iff (!presetn)
        (is_begin, a = sram_addr[1:0]) |=> (cur_lo == a);
    endproperty
    a_begin_load: assert property (p_begin_load) else $error("burst start not loaded");

    property p_cont_step;
        @(posedge pclk) disable iff (!presetn)
        is_cont |=> (cur_lo == $past(cyc_lo)) && ($past(cyc_lo) != $past(cur_lo));
    endproperty
    a_cont_step: assert property (p_cont_step) else $error("continue did not advance");

    property p_susp_hold;
        @(posedge pclk) disable iff (!presetn)
        (op == sbs_pkg::op_susp_rd || op == sbs_pkg::op_susp_wr) |=> $stable(cur_lo);
    endproperty
    a_susp_hold: assert property (p_susp_hold) else $error("suspend moved counter");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        is_begin ##1 is_cont [*4] |=> (cur_lo == $past(sram_addr[1:0], 5));
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst did not wrap on fifth clock");

    property p_write_hiz;
        @(posedge pclk) disable iff (!presetn)
        is_wr |=> (dq_oe_n == 4'hf);
    endproperty
    a_write_hiz: assert property (p_write_hiz) else $error("drivers on after write");

    property p_oe_off;
        @(posedge pclk) disable iff (!presetn)
        out_en_n |-> (dq_oe_n == 4'hf);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output enable high but driving");

    property p_no_lane;
        @(posedge pclk) disable iff (!presetn)
        (is_wr && global_write_n && lane_a_wr_n && lane_b_wr_n && lane_c_wr_n && lane_d_wr_n)
        |=> $stable(wr_count);
    endproperty
    a_no_lane: assert property (p_no_lane) else $error("write with no lane stored");

    property p_desel_keep;
        @(posedge pclk) disable iff (!presetn)
        // Counter state, not the mapped value: the order pin may move meanwhile
        (op == sbs_pkg::op_deselect) |-> (lane_wr == 4'h0) ##1 $stable({u_burst.base, u_burst.cnt});
    endproperty
    a_desel_keep: assert property (p_desel_keep) else $error("deselect changed state");

    property p_x18_lanes;
        @(posedge pclk) disable iff (!presetn)
        (width_cfg == sbs_pkg::WIDTH_X18) |-> (dq_oe_n[3:2] == 2'h3) && (lane_wr[3:2] == 2'h0);
    endproperty
    a_x18_lanes: assert property (p_x18_lanes) else $error("x18 used upper lanes");
endmodule

// ### sbs_pkg.sv
// Shared constants and types for the burst SRAM cycle control block
package sbs_pkg;
    // ==========================================================
    // Array geometry
    localparam int ADDR_W = 18;
    localparam int DEPTH = 262144;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = 36;

    // ==========================================================
    // Register map (byte addresses)
    localparam int PADDR_W = 12;
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] WRCNT_OFF = 12'h008;

    // Control register: bus width selection
    localparam int CTRL_WIDTH_LSB = 0;
    localparam logic [1:0] WIDTH_X18 = 2'h0;
    localparam logic [1:0] WIDTH_X32 = 2'h1;
    localparam logic [1:0] WIDTH_X36 = 2'h2;
    localparam logic [1:0] CTRL_RESET = WIDTH_X36;

    // Status register fields
    localparam int STAT_OP_LSB = 0;
    localparam int STAT_LO_LSB = 3;
    localparam int STAT_SLEEP_BIT = 5;
    localparam int STAT_FLOW_BIT = 6;
    localparam int STAT_DRIVE_BIT = 7;

    localparam int WRCNT_W = 16;
    localparam logic [15:0] WRCNT_RESET = 16'h0000;

    // ==========================================================
    // Synchronous cycle types
    typedef enum logic [2:0] {
        op_deselect,
        op_begin_rd,
        op_begin_wr,
        op_cont_rd,
        op_cont_wr,
        op_susp_rd,
        op_susp_wr
    } op_t;
endpackage

// ### sram_host.sv
// Host controller model driving the burst SRAM control and data inputs
module sram_host (
    // Clock
    input wire logic pclk,
    // Enables and strobes
    output logic chip_sel_primary_n,
    output logic chip_sel_high,
    output logic chip_sel_third_n,
    output logic proc_addr_strobe_n,
    output logic ctrl_addr_strobe_n,
    output logic burst_step_n,
    // Write controls
    output logic global_write_n,
    output logic byte_write_n,
    output logic lane_a_wr_n,
    output logic lane_b_wr_n,
    output logic lane_c_wr_n,
    output logic lane_d_wr_n,
    // Output enable, address and data
    output logic out_en_n,
    output logic [17:0] sram_addr,
    output logic [35:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========
    // Idle: deselected, no write
    initial begin
        {chip_sel_primary_n, chip_sel_high, chip_sel_third_n} = 3'h6;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h5;
        {global_write_n, byte_write_n} = 2'h3;
        {lane_a_wr_n, lane_b_wr_n, lane_c_wr_n, lane_d_wr_n} = 4'hf;
        out_en_n = 1'b1;
        sram_addr = 18'h0;
        dq_in = 36'h0;
    end

    // ========
    // One synchronous cycle, launched just after a rising edge
    task automatic op(input logic [5:0] s, input logic [5:0] w, input logic o,
                      input logic [17:0] a, input logic [35:0] d);
        @(posedge pclk);
        {chip_sel_primary_n, chip_sel_high, chip_sel_third_n} <= s[5:3];
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} <= s[2:0];
        {global_write_n, byte_write_n} <= w[5:4];
        {lane_a_wr_n, lane_b_wr_n, lane_c_wr_n, lane_d_wr_n} <= w[3:0];
        // Drivers must be off before write data goes on the bus
        out_en_n <= o | (w[5:4] != 2'h3);
        sram_addr <= a;
        // Released bus toggles so stale data never looks valid
        dq_in <= (w[5:4] != 2'h3) ? d : ~dq_in;
    endtask
endmodule

// ### sync_burst_sram_cycle_control_tb.sv
// Self-checking bench for the burst SRAM cycle control block
module sync_burst_sram_cycle_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ========
    // Strobe sets {e1_n, e2, e3_n, proc_addr_strobe_n_n, ctrl_addr_strobe_n_n, adv_n}
    localparam logic [5:0] bg_p = 6'h13;
    localparam logic [5:0] bg_c = 6'h15;
    localparam logic [5:0] cont = 6'h16;
    localparam logic [5:0] cont_h = 6'h22;
    localparam logic [5:0] sus = 6'h17;
    localparam logic [5:0] des_h = 6'h35;
    localparam logic [5:0] des_l = 6'h03;
    // Write sets {gw_n, bw_n, a, b, c, d}
    localparam logic [5:0] rdw = 6'h3f;
    localparam logic [5:0] gw = 6'h1f;
    localparam logic [35:0] nd = 36'h9a5c3e71b;

    typedef struct {
        logic [5:0] s;
        logic [5:0] w;
        logic o;
        logic [17:0] a;
        logic [35:0] d;
        logic [3:0] eo;
        logic [35:0] ed;
    } step_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic chip_sel_primary_n, chip_sel_high, chip_sel_third_n;
    logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n;
    logic global_write_n, byte_write_n;
    logic lane_a_wr_n, lane_b_wr_n, lane_c_wr_n, lane_d_wr_n;
    logic out_en_n;
    logic sleep_req = 1'b0;
    logic flow_thru_sel_n = 1'b0;
    logic linear_order_n = 1'b0;
    logic [17:0] sram_addr;
    logic [35:0] dq_in;
    logic [35:0] dq_out;
    logic [3:0] dq_oe_n;
    logic [35:0] acc;
    step_t q[$];
    int miscompares = 0;
    int checks_done = 0;

    always #2.5 pclk = ~pclk;

    sram_host i_host (.*);
    sbs_cycle_ctrl i_dut (.*);

    // ========
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_rd(input string what, input logic [11:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(what, 36'(rd), 36'(e));
        chk({what, " err"}, 36'(err), 36'(ee));
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    function automatic logic [35:0] dat(input logic [17:0] a);
        return {a[8:0], ~a[8:0], a[8:0] ^ 9'h155, a[8:0] ^ 9'h0f0};
    endfunction

    task automatic p(input logic [5:0] s, input logic [5:0] w, input logic o, input logic [17:0] a,
                     input logic [35:0] d, input logic [3:0] eo, input logic [35:0] ed);
        q.push_back('{s, w, o, a, d, eo, ed});
    endtask

    // Outcome of a cycle shows lat edges after it is launched
    // Output enable in force then is that of the cycle just launched
    task automatic run(input int lat);
        int n;
        n = q.size();
        for (int j = 0; j < lat; j++) p(des_h, rdw, 1'b0, 18'h0, 36'h0, 4'hf, 36'h0);
        for (int j = 0; j < q.size(); j++) begin
            i_host.op(q[j].s, q[j].w, q[j].o, q[j].a, q[j].d);
            if (j >= lat) begin
                @(negedge pclk);
                chk($sformatf("oe %0d", j - lat), 36'(dq_oe_n), 36'(q[j - lat].eo));
                if (q[j - lat].ed != 36'h0) chk($sformatf("dq %0d", j - lat), dq_out, q[j - lat].ed);
            end
        end
        q.delete();
    endtask

    // ========
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        reg_rd("ctrl", sbs_pkg::CTRL_OFF, 32'(sbs_pkg::CTRL_RESET), 1'b0);
        reg_rd("wrcnt", sbs_pkg::WRCNT_OFF, 32'h0, 1'b0);
        reg_rd("status", sbs_pkg::STATUS_OFF, 32'h1 << sbs_pkg::STAT_FLOW_BIT, 1'b0);
        reg_rd("unmapped", 12'h00c, 32'h0, 1'b1);
        reg_wr(sbs_pkg::CTRL_OFF, 32'h3);
        reg_rd("ctrl bad", sbs_pkg::CTRL_OFF, 32'(sbs_pkg::WIDTH_X36), 1'b0);
        $display("test registers done");

        p(bg_c, gw, 1'b1, 18'h100, dat(18'h100), 4'hf, 36'h0);
        p(cont, gw, 1'b1, 18'h0, dat(18'h101), 4'hf, 36'h0);
        p(cont_h, gw, 1'b1, 18'h0, dat(18'h102), 4'hf, 36'h0);
        p(cont, gw, 1'b1, 18'h0, dat(18'h103), 4'hf, 36'h0);
        p(sus, gw, 1'b1, 18'h0, dat(18'h103), 4'hf, 36'h0);
        p(des_l, gw, 1'b1, 18'h101, 36'h0, 4'hf, 36'h0);
        p(bg_p, 6'h00, 1'b0, 18'h101, 36'h0, 4'h0, dat(18'h101));
        p(cont, rdw, 1'b0, 18'h0, 36'h0, 4'h0, dat(18'h102));
        p(cont, rdw, 1'b0, 18'h0, 36'h0, 4'h0, dat(18'h103));
        p(cont, rdw, 1'b0, 18'h0, 36'h0, 4'h0, dat(18'h100));
        p(cont, rdw, 1'b0, 18'h0, 36'h0, 4'h0, dat(18'h101));
        p(sus, rdw, 1'b0, 18'h0, 36'h0, 4'h0, dat(18'h101));
        p(des_h, rdw, 1'b0, 18'h0, 36'h0, 4'hf, 36'h0);
        p(cont, rdw, 1'b0, 18'h0, 36'h0, 4'h0, dat(18'h102));
        run(1);
        $display("test linear burst done");

        @(posedge pclk);
        linear_order_n <= 1'b1;
        // Base 01 tells interleaved order from linear
        p(bg_c, rdw, 1'b0, 18'h101, 36'h0, 4'h0, dat(18'h101));
        p(cont, rdw, 1'b0, 18'h0, 36'h0, 4'hf, dat(18'h100));
        p(cont, rdw, 1'b1, 18'h0, 36'h0, 4'hf, dat(18'h103));
        p(cont, gw, 1'b1, 18'h0, nd, 4'hf, 36'h0);
        p(bg_p, rdw, 1'b0, 18'h102, 36'h0, 4'h0, nd);
        run(1);
        $display("test dummy read done");

        acc = 36'h0;
        p(bg_c, gw, 1'b1, 18'h200, 36'h0, 4'hf, 36'h0);
        for (int i = 0; i < 4; i++) begin
            acc = acc | (36'h1ff << (9 * i));
            p(bg_c, {2'h2, ~(4'h8 >> i)}, 1'b1, 18'h200, ~36'h0, 4'hf, 36'h0);
            // Next cycle writes, so output enable is already high
            p(bg_c, rdw, 1'b0, 18'h200, 36'h0, 4'hf, acc);
        end
        p(bg_c, 6'h2f, 1'b1, 18'h200, 36'h0, 4'hf, 36'h0);
        p(bg_c, rdw, 1'b0, 18'h200, 36'h0, 4'hf, ~36'h0);
        p(bg_c, 6'h25, 1'b1, 18'h200, 36'h0, 4'hf, 36'h0);
        p(bg_c, rdw, 1'b0, 18'h200, 36'h0, 4'h0, {9'h1ff, 9'h0, 9'h1ff, 9'h0});
        run(1);
        reg_rd("wrcnt", sbs_pkg::WRCNT_OFF, 32'hc, 1'b0);
        $display("test byte write done");

        reg_wr(sbs_pkg::CTRL_OFF, 32'(sbs_pkg::WIDTH_X18));
        p(bg_c, gw, 1'b1, 18'h300, dat(18'h300), 4'hf, 36'h0);
        p(bg_p, rdw, 1'b0, 18'h300, 36'h0, 4'hc, dat(18'h300) & 36'h3ffff);
        run(1);
        reg_wr(sbs_pkg::CTRL_OFF, 32'(sbs_pkg::WIDTH_X32));
        p(bg_p, rdw, 1'b0, 18'h102, 36'h0, 4'h0, nd & {4{9'h0ff}});
        run(1);
        reg_wr(sbs_pkg::CTRL_OFF, 32'(sbs_pkg::WIDTH_X36));
        $display("test width done");

        @(posedge pclk);
        flow_thru_sel_n <= 1'b1;
        p(bg_p, rdw, 1'b0, 18'h103, 36'h0, 4'h0, dat(18'h103));
        p(cont, rdw, 1'b0, 18'h0, 36'h0, 4'h0, nd);
        run(2);
        @(posedge pclk);
        sleep_req <= 1'b1;
        p(bg_p, rdw, 1'b0, 18'h100, 36'h0, 4'hf, 36'h0);
        run(2);
        $display("test pipeline and sleep done");
        complete_run();
    end
endmodule
